// >>> include/regfile_params.svh
/*
  Constants of the banked register file and the arithmetic status register.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef REGFILE_PARAMS_SVH
`define REGFILE_PARAMS_SVH

// Fixed register locations in the file (register index).
`define RF_INDIRECT_DATA0   8'h00
`define RF_INDIRECT_PTR0    8'h01
`define RF_ARITH_STATUS     8'h04
`define RF_INDIRECT_DATA1   8'h08
`define RF_INDIRECT_PTR1    8'h09
`define RF_BANK_SELECT      8'h0F

// Window limits.
`define RF_SFR_BANKED_LO    8'h10
`define RF_SFR_BANKED_HI    8'h17
`define RF_COMMON_LO        8'h1A
`define RF_COMMON_HI        8'h1F
`define RF_GPR_LO           8'h20

// Arithmetic status field positions.
`define ST_PTR1_MODE_HI     7
`define ST_PTR1_MODE_LO     6
`define ST_PTR0_MODE_HI     5
`define ST_PTR0_MODE_LO     4
`define ST_WRAP             3
`define ST_ZERO             2
`define ST_NIBBLE           1
`define ST_CARRY            0

// Reset values.
`define ST_RESET            8'hF0
`define BANK_SELECT_RESET   8'h00
`define PTR_RESET           8'h00

// Pointer post-modify encodings.
`define MODE_DEC            2'h0
`define MODE_INC            2'h1

// APB byte address to register index: index lives in these address bits.
`define APB_IDX_HI          9
`define APB_IDX_LO          2

// Address bits above the register window; any one of them set answers with an error.
`define APB_ERR_HI          11
`define APB_ERR_LO          10

// RAM banks left out on the small variant.
`define RF_SMALL_GAP_LO     4'h2
`define RF_SMALL_GAP_HI     4'h3

`endif

// >>> include/regfile_pkg.sv
/*
  Types shared by the banked register file.
  Assumes regfile_params.svh is available on the include path.
*/
package regfile_pkg;

  // Operation requested by the core for one instruction cycle.
  typedef enum logic [2:0] {
    OP_ADD  = 3'h0,
    OP_SUB  = 3'h1,
    OP_AND  = 3'h2,
    OP_IOR  = 3'h3,
    OP_XOR  = 3'h4,
    OP_RLC  = 3'h5,
    OP_RRC  = 3'h6
  } alu_op_e;

  // Phase of the APB access.
  typedef enum logic [1:0] {
    PH_WAIT = 2'b01,
    PH_DONE = 2'b10
  } apb_phase_e;

endpackage

// >>> rtl/banked_register_file_alu_status.sv
/*
  Banked data register file with the arithmetic status register, reached over
  APB with one wait state, and an ALU flag port driven by the core.
  Register index map (byte address is four times the index):
    00h and 08h are the two indirect data ports, 01h and 09h their pointers,
    04h the arithmetic status, 0Fh the bank select register,
    10h-17h special slots banked by the low bank nibble,
    1Ah-1Fh common RAM, 20h-FFh RAM banked by the high bank nibble,
    every other index one plain unbanked register.
  APB timing: read data is latched on the first access edge, pready rises on that
  same edge, and writes and pointer post-modify land at the completing edge.
  Assumes all inputs come from logic on clk_i, an APB master that holds each
  request until it samples pready high, and that the peripheral registers
  behind the banked slots are plain storage here.
*/
// Implementation choice: the APB slave port.
`include "regfile_params.svh"
`timescale 1ns/1ns
`default_nettype none

module banked_register_file_alu_status
  import regfile_pkg::*;
#(
  parameter int GPR_BANKS     = 4,
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        alu_go_i,
  input  wire alu_op_e     alu_op_i,
  input  wire logic [7:0]  alu_a_i,
  input  wire logic [7:0]  alu_b_i,
  output logic      [7:0]  alu_result_o,
  output logic      [7:0]  arith_status_o
);

  // Address width of the RAM array over every bank the parameter allows.
  localparam int GW = $clog2(GPR_BANKS * 256);

  // Control registers.
  logic [7:0]  arith_status_q;
  logic [7:0]  arith_status_d;
  logic [7:0]  indirect_pointer0_q;
  logic [7:0]  indirect_pointer0_d;
  logic [7:0]  indirect_pointer1_q;
  logic [7:0]  indirect_pointer1_d;
  logic [7:0]  bank_select_reg_q;
  logic [7:0]  bank_select_reg_d;
  apb_phase_e  phase_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [7:0]  alu_result_q;
  logic        pready_q;

  // Storage arrays; contents are undefined after reset, as in the part.
  // The small variant's absent banks 2 and 3 keep their rows in the array, so the index stays a plain slice.
  logic [7:0] sfr_mem    [0:127];
  logic [7:0] common_mem [0:7];
  logic [7:0] misc_mem   [0:31];
  logic [7:0] gpr_mem    [0:GPR_BANKS*256-1];

  // APB decode.
  wire        apb_access = psel_i & penable_i;
  wire        apb_sample = apb_access & (phase_q == PH_WAIT);
  wire        apb_finish = apb_access & (phase_q == PH_DONE);
  wire [7:0]  reg_idx    = paddr_i[`APB_IDX_HI:`APB_IDX_LO];
  wire        addr_high  = paddr_i[`APB_ERR_HI:`APB_ERR_LO] != 2'h0;
  // Only the low byte lane carries register data; the upper lanes are ignored.
  wire        wr_lane    = pwrite_i & pstrb_i[0] & ~addr_high;
  wire        do_write   = apb_finish & wr_lane;

  wire        via_ptr0   = reg_idx == `RF_INDIRECT_DATA0;
  wire        via_ptr1   = reg_idx == `RF_INDIRECT_DATA1;
  wire [7:0]  tgt        = via_ptr0 ? indirect_pointer0_q :
                           via_ptr1 ? indirect_pointer1_q : reg_idx;
  // A completed access to a data port, read or write, post-modifies its pointer.
  wire        port0_done = apb_finish & ~addr_high & via_ptr0;
  wire        port1_done = apb_finish & ~addr_high & via_ptr1;

  // Target class; an indirect access that points at a data port itself goes nowhere.
  wire        t_port     = (tgt == `RF_INDIRECT_DATA0) | (tgt == `RF_INDIRECT_DATA1);
  wire        t_ptr0     = tgt == `RF_INDIRECT_PTR0;
  wire        t_ptr1     = tgt == `RF_INDIRECT_PTR1;
  wire        t_status   = tgt == `RF_ARITH_STATUS;
  wire        t_bank     = tgt == `RF_BANK_SELECT;
  wire        t_sfr      = (tgt >= `RF_SFR_BANKED_LO) & (tgt <= `RF_SFR_BANKED_HI);
  wire        t_common   = (tgt >= `RF_COMMON_LO) & (tgt <= `RF_COMMON_HI);
  wire        t_gpr      = tgt >= `RF_GPR_LO;
  // Whatever is left over is one plain unbanked register, so no index is unmapped.
  wire        t_misc     = ~(t_port | t_ptr0 | t_ptr1 | t_status | t_bank | t_sfr | t_common | t_gpr);

  wire [6:0]  sfr_idx    = {bank_select_reg_q[3:0], tgt[2:0]};
  wire [2:0]  common_idx = tgt[2:0];
  wire [4:0]  misc_idx   = tgt[4:0];

  // RAM bank from the high nibble
  wire [3:0]  gpr_bank   = bank_select_reg_q[7:4];
  wire [11:0] gpr_full   = {gpr_bank, tgt};
  wire [GW-1:0] gpr_idx  = gpr_full[GW-1:0];
  wire        small_gap  = SMALL_VARIANT & ((gpr_bank == `RF_SMALL_GAP_LO) | (gpr_bank == `RF_SMALL_GAP_HI));
  wire        gpr_ok     = (32'(gpr_bank) < GPR_BANKS) & ~small_gap;

  // Read multiplexer.
  // A pointer aimed at a data port falls through to zero rather than recursing.
  wire [7:0]  rd_val     = t_ptr0   ? indirect_pointer0_q :
                           t_ptr1   ? indirect_pointer1_q :
                           t_status ? arith_status_q :
                           t_bank   ? bank_select_reg_q :
                           t_sfr    ? sfr_mem[sfr_idx] :
                           t_common ? common_mem[common_idx] :
                           (t_gpr & gpr_ok) ? gpr_mem[gpr_idx] :
                           t_misc   ? misc_mem[misc_idx] : 8'h00;

  // Write enables per target; a write to an absent RAM bank is dropped so it cannot alias a real one.
  wire        wr_status  = do_write & t_status;
  wire        wr_ptr0    = do_write & t_ptr0;
  wire        wr_ptr1    = do_write & t_ptr1;
  wire        wr_bank    = do_write & t_bank;
  wire        wr_sfr     = do_write & t_sfr;
  wire        wr_common  = do_write & t_common;
  wire        wr_gpr     = do_write & t_gpr & gpr_ok;
  wire        wr_misc    = do_write & t_misc;

  // Post-modify actions of both pointers.
  wire [1:0]  mode0      = arith_status_q[`ST_PTR0_MODE_HI:`ST_PTR0_MODE_LO];
  wire [1:0]  mode1      = arith_status_q[`ST_PTR1_MODE_HI:`ST_PTR1_MODE_LO];

  // Codes 1x fall through and hold the pointer; steps wrap modulo 256.
  function automatic logic [7:0] post_mod(input logic [1:0] mode, input logic [7:0] ptr);
    logic [7:0] r;
    r = ptr;
    if (mode == `MODE_DEC) begin
      r = ptr - 8'h01;
    end else if (mode == `MODE_INC) begin
      r = ptr + 8'h01;
    end
    return r;
  endfunction

  // ALU datapath; subtraction feeds the inverted operand and a carry in of one.
  // The nibble sum is its own adder so the digit carry needs no tap inside the byte sum.
  wire        is_sub     = alu_op_i == OP_SUB;
  wire        is_arith   = (alu_op_i == OP_ADD) | is_sub;
  wire        is_rot     = (alu_op_i == OP_RLC) | (alu_op_i == OP_RRC);
  wire        carry_in   = arith_status_q[`ST_CARRY];
  wire [7:0]  b_eff      = is_sub ? ~alu_b_i : alu_b_i;
  wire [8:0]  sum9       = {1'b0, alu_a_i} + {1'b0, b_eff} + {8'h00, is_sub};
  wire [4:0]  nib5       = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};
  wire        wrap       = (alu_a_i[7] == b_eff[7]) & (sum9[7] != alu_a_i[7]);

  logic [7:0] alu_val;
  logic       rot_out;

  // Result selection; rotates shift the old carry in at the far end.
  always_comb begin
    alu_val = 8'h00;
    rot_out = 1'b0;
    unique case (alu_op_i)
      OP_ADD, OP_SUB: begin
        alu_val = sum9[7:0];
      end
      OP_AND: begin
        alu_val = alu_a_i & alu_b_i;
      end
      OP_IOR: begin
        alu_val = alu_a_i | alu_b_i;
      end
      OP_XOR: begin
        alu_val = alu_a_i ^ alu_b_i;
      end
      OP_RLC: begin
        alu_val = {alu_a_i[6:0], carry_in};
        rot_out = alu_a_i[7];
      end
      OP_RRC: begin
        alu_val = {carry_in, alu_a_i[7:1]};
        rot_out = alu_a_i[0];
      end
      default: begin
        alu_val = alu_a_i;
      end
    endcase
  end

  // Status next value: software writes first, the ALU's flags override them.
  always_comb begin
    arith_status_d = arith_status_q;
    if (wr_status) begin
      arith_status_d = pwdata_i[7:0];
    end
    if (alu_go_i) begin
      if (is_arith) begin
        arith_status_d[`ST_WRAP]   = wrap;
        arith_status_d[`ST_NIBBLE] = nib5[4];
        arith_status_d[`ST_CARRY]  = sum9[8];
      end
      if (is_rot) begin
        arith_status_d[`ST_CARRY] = rot_out;
      end else begin
        arith_status_d[`ST_ZERO] = alu_val == 8'h00;
      end
    end
  end

  // Pointer and bank next values; a direct write wins over post-modify.
  // The port is decoded before the pointer moves, so one access steps it once.
  always_comb begin
    indirect_pointer0_d = indirect_pointer0_q;
    indirect_pointer1_d = indirect_pointer1_q;
    bank_select_reg_d   = bank_select_reg_q;
    if (port0_done) begin
      indirect_pointer0_d = post_mod(mode0, indirect_pointer0_q);
    end
    if (port1_done) begin
      indirect_pointer1_d = post_mod(mode1, indirect_pointer1_q);
    end
    if (wr_ptr0) begin
      indirect_pointer0_d = pwdata_i[7:0];
    end
    if (wr_ptr1) begin
      indirect_pointer1_d = pwdata_i[7:0];
    end
    if (wr_bank) begin
      bank_select_reg_d = pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      arith_status_q <= `ST_RESET;
    end else if (ce_i) begin
      arith_status_q <= arith_status_d;
    end
  end

  // The result stands until the next operation, so the core may read it late on alu_result_o.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      alu_result_q <= 8'h00;
    end else if (ce_i & alu_go_i) begin
      alu_result_q <= alu_val;
    end
  end

  // Pointers and bank select.
  // They change only at a completed access, never on the latching edge.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      indirect_pointer0_q <= `PTR_RESET;
      indirect_pointer1_q <= `PTR_RESET;
      bank_select_reg_q   <= `BANK_SELECT_RESET;
    end else if (ce_i) begin
      indirect_pointer0_q <= indirect_pointer0_d;
      indirect_pointer1_q <= indirect_pointer1_d;
      bank_select_reg_q   <= bank_select_reg_d;
    end
  end

  // APB handshake: one wait state gives time to register the read data.
  // Read data comes from the pre-access pointer, so a post-modify never shows in the same read.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q   <= PH_WAIT;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce_i) begin
      if (apb_sample) begin
        phase_q   <= PH_DONE;
        pready_q  <= 1'b1;
        prdata_q  <= {24'h00_0000, addr_high ? 8'h00 : rd_val};
        pslverr_q <= addr_high;
      end else if (apb_finish) begin
        phase_q   <= PH_WAIT;
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Storage writes; arrays carry no reset so they map onto RAM.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (wr_sfr) begin
        sfr_mem[sfr_idx] <= pwdata_i[7:0];
      end
      if (wr_common) begin
        common_mem[common_idx] <= pwdata_i[7:0];
      end
      if (wr_gpr) begin
        gpr_mem[gpr_idx] <= pwdata_i[7:0];
      end
      if (wr_misc) begin
        misc_mem[misc_idx] <= pwdata_i[7:0];
      end
    end
  end

  assign prdata_o       = prdata_q;
  assign pready_o       = pready_q;
  assign pslverr_o      = pslverr_q;
  assign alu_result_o   = alu_result_q;
  assign arith_status_o = arith_status_q;

endmodule

`default_nettype wire

// >>> verification/regfile_chk.sv
/*
  Port checker for the banked register file and its status register.
  Assumes it is bound to the design top and everything runs on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module regfile_chk
  import regfile_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        alu_go_i,
  input wire alu_op_e     alu_op_i,
  input wire logic [7:0]  alu_a_i,
  input wire logic [7:0]  alu_b_i,
  input wire logic [7:0]  alu_result_o,
  input wire logic [7:0]  arith_status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic       c_q;
  // Operands and old carry of the cycle an operation is taken.
  always_ff @(posedge clk_i) begin
    a_q <= alu_a_i;
    b_q <= alu_b_i;
    c_q <= arith_status_o[0];
  end
  sequence alu_take(alu_op_e k);
    alu_go_i && ce_i && alu_op_i == k;
  endsequence
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held two cycles");
  bad_addr_a: assert property (pready_o && paddr_i[11:10] != 2'h0 |-> pslverr_o && prdata_o == 32'h0)
    else $error("bad address answered");
  mode_hold_a: assert property (!(pready_o && pwrite_i) |=> $stable(arith_status_o[7:4]))
    else $error("modes changed");
  add_flags_a: assert property (alu_take(OP_ADD) |=> arith_status_o[0] == (a_q + b_q > 9'h0FF)
    && arith_status_o[1] == (a_q[3:0] + b_q[3:0] > 5'h0F))
    else $error("add carry wrong");
  sub_flags_a: assert property (alu_take(OP_SUB) |=> arith_status_o[0] == (a_q >= b_q)
    && arith_status_o[1] == (a_q[3:0] >= b_q[3:0]))
    else $error("sub borrow wrong");
  wrap_flag_a: assert property (alu_take(OP_ADD) |=> arith_status_o[3] ==
    (a_q[7] == b_q[7] && alu_result_o[7] != a_q[7]))
    else $error("wrap wrong");
  zero_flag_a: assert property (alu_go_i && ce_i && alu_op_i inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR}
    |=> arith_status_o[2] == (alu_result_o == 8'h00))
    else $error("zero wrong");
  rot_left_a: assert property (alu_take(OP_RLC) |=> arith_status_o[0] == a_q[7] && alu_result_o == {a_q[6:0], c_q})
    else $error("left rotate wrong");
  rot_right_a: assert property (alu_take(OP_RRC) |=> arith_status_o[0] == a_q[0] && alu_result_o == {c_q, a_q[7:1]})
    else $error("right rotate wrong");
  hold_frozen_a: assert property (!ce_i |=> $stable(arith_status_o) && $stable(alu_result_o))
    else $error("state moved while clock enable low");
endmodule
bind banked_register_file_alu_status regfile_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .alu_go_i(alu_go_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i), .alu_b_i(alu_b_i),
  .alu_result_o(alu_result_o), .arith_status_o(arith_status_o));
`default_nettype wire

// >>> verification/core_model.sv
/*
  Core model issuing one ALU operation per call.
  Assumes one caller, entering right after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model
  import regfile_pkg::*;
(
  input  wire logic       clk_i,
  output logic            go_o,
  output alu_op_e         op_o,
  output logic      [7:0] a_o,
  output logic      [7:0] b_o
);
  initial begin
    go_o = 1'b0;
    op_o = OP_ADD;
    a_o = 8'h00;
    b_o = 8'h00;
  end
  // One pulse; afterwards the operands turn over so stale values never look valid.
  task automatic issue(input alu_op_e op, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_i);
    go_o <= 1'b1;
    op_o <= op;
    a_o <= a;
    b_o <= b;
    @(posedge clk_i);
    go_o <= 1'b0;
    a_o <= ~a;
    b_o <= ~b;
  endtask
endmodule
`default_nettype wire

// >>> verification/banked_register_file_alu_status_test.sv
/*
  Self-checking bench for the banked register file.
  Assumes the core model drives the ALU port and the bench is APB master.
*/
`timescale 1ns/1ns
`default_nettype none
module banked_register_file_alu_status_test;
  import regfile_pkg::*;
  logic        clk_i, reset_i, ce, psel, pen, pwr, go, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, prdata_small, rd_small;
  logic [7:0]  a, b, res, st;
  alu_op_e     op;
  int          err_total, checks, cyc;
  banked_register_file_alu_status DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .alu_go_i(go), .alu_op_i(op), .alu_a_i(a), .alu_b_i(b),
    .alu_result_o(res), .arith_status_o(st));
  // Small-variant twin on the same bus; it answers in step, and only its read data is compared.
  banked_register_file_alu_status #(.SMALL_VARIANT(1'b1)) DUT_SMALL (.clk_i(clk_i), .reset_i(reset_i),
    .ce_i(ce), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata_small), .pready_o(), .pslverr_o(), .alu_go_i(go), .alu_op_i(op),
    .alu_a_i(a), .alu_b_i(b), .alu_result_o(), .arith_status_o());
  core_model core (.clk_i(clk_i), .go_o(go), .op_o(op), .a_o(a), .b_o(b));
  // Free-running clock and a hang guard.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until ready is sampled high.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    paddr <= {idx, 2'b00};
    pwr <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    rd_small = prdata_small;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    apb(0, 10'h004, 0); check(rd, 32'hF0);
    apb(0, 10'h30F, 0); check(rd, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_sfr();
    for (int i = 0; i < 16; i++) begin
      apb(1, 10'h00F, i[7:0]); apb(1, 10'h010, 8'hA0 + i[7:0]); apb(1, 10'h00A, i[7:0]);
    end
    for (int i = 0; i < 16; i++) begin
      apb(1, 10'h00F, i[7:0]); apb(0, 10'h010, 0); check(rd, 32'hA0 + i);
      apb(0, 10'h00A, 0); check(rd, 32'h0F);
    end
    $display("t_sfr done");
  endtask
  task automatic t_gpr();
    for (int i = 0; i < 5; i++) begin
      apb(1, 10'h00F, {i[3:0], 4'h0}); apb(1, 10'h020, 8'h50 + i[7:0]);
      apb(1, 10'h0FF, 8'h60 + i[7:0]); apb(1, 10'h01A, i[7:0]);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1, 10'h00F, {i[3:0], 4'h0}); apb(0, 10'h020, 0); check(rd, i < 4 ? 32'h50 + i : 0);
      check(rd_small, i < 2 ? 32'h50 + i : 0);
      apb(0, 10'h0FF, 0); check(rd, i < 4 ? 32'h60 + i : 0);
      check(rd_small, i < 2 ? 32'h60 + i : 0);
      apb(0, 10'h01A, 0); check(rd, 32'h04);
    end
    apb(1, 10'h00F, 8'h00);
    $display("t_gpr done");
  endtask
  task automatic t_ind();
    logic [7:0] m, e;
    apb(1, 10'h03F, 8'h3B); apb(1, 10'h040, 8'h3C); apb(1, 10'h041, 8'h3D);
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 3; k++) begin
        m = (k == 2) ? 8'h2 : k[7:0];
        e = (k == 0) ? 8'h3F : (k == 1) ? 8'h41 : 8'h40;
        apb(1, p ? 10'h009 : 10'h001, 8'h40);
        apb(1, 10'h004, p ? {m[1:0], 6'h30} : {2'h3, m[1:0], 4'h0});
        apb(0, p ? 10'h008 : 10'h000, 0); check(rd, 32'h3C);
        apb(0, p ? 10'h009 : 10'h001, 0); check(rd, {24'h0, e});
        apb(0, p ? 10'h008 : 10'h000, 0); check(rd, {24'h0, e - 8'h04});
      end
    apb(1, 10'h004, 8'hF0);
    $display("t_ind done");
  endtask
  task automatic t_alu();
    alu_op_e    ops [10] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_AND, OP_XOR, OP_IOR, OP_RLC, OP_RRC};
    logic [7:0] av [10] = '{8'h0F, 8'h80, 8'h7F, 8'h05, 8'h03, 8'h0F, 8'h5A, 8'h12, 8'h81, 8'h01};
    logic [7:0] bv [10] = '{8'h01, 8'h80, 8'h01, 8'h05, 8'h05, 8'hF0, 8'h5A, 8'h21, 8'h00, 8'h00};
    logic [7:0] rv [10] = '{8'h10, 8'h00, 8'h80, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h33, 8'h02, 8'h80};
    logic [3:0] fv [10] = '{4'h2, 4'hD, 4'hA, 4'h7, 4'h0, 4'h4, 4'h4, 4'h0, 4'h1, 4'h1};
    for (int i = 0; i < 10; i++) begin
      core.issue(ops[i], av[i], bv[i]);
      @(negedge clk_i);
      check(res, rv[i]);
      check(st, {4'hF, fv[i]});
    end
    @(posedge clk_i);
    apb(0, 10'h004, 0); check(rd, 32'hF1);
    $display("t_alu done");
  endtask
  // Clock enable low: an operation offered meanwhile must leave flags and result alone.
  task automatic t_hold();
    ce <= 1'b0;
    core.issue(OP_ADD, 8'hFF, 8'h01);
    @(negedge clk_i);
    check({24'h0, st}, 32'hF1);
    check({24'h0, res}, 32'h80);
    @(posedge clk_i);
    ce <= 1'b1;
    $display("t_hold done");
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    {psel, pen, pwr, paddr, pwdata} = '0;
    ce = 1'b1;
    reset_i = 1'b1;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_sfr();
    t_gpr();
    t_ind();
    t_alu();
    t_hold();
    test_done();
  end
endmodule
`default_nettype wire
